/* File: pkg/mlag_map.vh */
// Purpose: Constants for the memory lock access guard
// Assumes: Included by bare name from design files
// Notes:   Definitions only
`ifndef MLAG_MAP_VH
`define MLAG_MAP_VH
// Lock key register
`define MLAG_KEY_OFFSET    8'h00
`define MLAG_KEY_UNLOCK    32'h5CC5C55C
`define MLAG_KEY_RESET     32'h5CC5C55C
// Memory section codes
`define MLAG_SEC_FLASH     3'h0
`define MLAG_SEC_SRAM      3'h1
`define MLAG_SEC_EEPROM    3'h2
`define MLAG_SEC_SIGNATURE_ROW   3'h3
`define MLAG_SEC_USER_CONFIG_ROW 3'h4
`define MLAG_SEC_FUSE      3'h5
`define MLAG_SEC_LOCK      3'h6
`define MLAG_SEC_REGS      3'h7
// Data returned for a denied read
`define MLAG_DENY_DATA     8'h00
// Bit position of the eeprom preserve bit in its fuse byte
`define MLAG_EEPROM_PRESERVE_POS 0
`endif

/* File: verilog/mlag_perm.v */
// Purpose: Access permission table for one requester
// Assumes: Section code as defined in the map header
// Notes:   Pure combinational lookup
`timescale 1ns/1ps
`include "mlag_map.vh"
module mlag_perm (
  // Request
  input  wire       is_debug,
  input  wire       locked,
  input  wire       fuse_cmd,
  input  wire [2:0] section,
  // Result
  output reg        rd_ok,
  output reg        wr_ok
);
  // Permission lookup
  always @* begin
    rd_ok = 1'b1;
    wr_ok = 1'b1;
    if (!is_debug) begin
      // CPU reads all; no write to signature, fuses or key
      if (section == `MLAG_SEC_SIGNATURE_ROW || section == `MLAG_SEC_FUSE ||
          section == `MLAG_SEC_LOCK)
        wr_ok = 1'b0;
    end else if (!locked) begin
      if (section == `MLAG_SEC_SIGNATURE_ROW)
        wr_ok = 1'b0;
    end else begin
      rd_ok = 1'b0;
      wr_ok = (section == `MLAG_SEC_USER_CONFIG_ROW) && fuse_cmd;
    end
  end
endmodule // mlag_perm

/* File: verilog/mlag_guard.v */
// Purpose: Lock key register and debug/CPU access gate
// Assumes: Key storage is nonvolatile; reset does not touch it
// Notes:   Key register models nonvolatile storage; RESETN leaves it alone.
//          Simulation starts unlocked from the initial key value.
//          One key serves both requesters; gating is combinational.
//          Gated strobes reach memory in the request cycle.
//          A denied debug access still acknowledges one cycle later.
//          Denied reads return fixed data, never memory contents.
//          The key never reaches the memory bus; it lives in the lock section.
//          Key bytes are picked by the two low address bits.
//          A byte that differs from the unlock value locks at the next edge.
//          Erase wins over a key write in the same cycle.
//          EEPROM erase is decided from the lock state before the erase.
//          CPU writes to protected sections are dropped without an error.
// Function
// - Unlocked only when the key equals the unlock value; else locked.
// - A debug write of any non-unlock value to the key locks the device.
// - CPU reads everything and writes flash, SRAM, EEPROM, user row, registers.
// - CPU never writes signature, fuses, key; unlocked debug writes all but signature.
// - Locked: debug reads and writes denied, except user row writes.
// - A denied read completes normally with data unrelated to memory.
// - Locked user row writes go through the fuse write command; reads stay hidden.
// - Only a full device erase unlocks, and it erases application data.
// - Erase while locked always clears EEPROM despite the preserve bit.
// - Key is 32 bits at offset zero, CPU read-only, starts unlocked, survives reset.
`timescale 1ns/1ps
`include "mlag_map.vh"
module mlag_guard (
  // Clock and reset
  input  wire        MCLK,
  input  wire        RESETN,
  // Debug port request
  input  wire        DBG_REQ,
  input  wire        DBG_WE,
  input  wire        DBG_FUSE_CMD,
  input  wire [2:0]  DBG_SECTION,
  input  wire [7:0]  DBG_ADDR,
  input  wire [7:0]  DBG_WDATA,
  // Debug port answer
  output reg  [7:0]  DBG_RDATA,
  output reg         DBG_ACK,
  // CPU request
  input  wire        CPU_REQ,
  input  wire        CPU_WE,
  input  wire [2:0]  CPU_SECTION,
  input  wire [7:0]  CPU_ADDR,
  // CPU answer
  output reg  [7:0]  CPU_RDATA,
  output reg         CPU_ACK,
  // Gated requests to the memory bus
  output wire        MEM_DBG_RD,
  output wire        MEM_DBG_WR,
  output wire        MEM_CPU_RD,
  output wire        MEM_CPU_WR,
  // Memory read data
  input  wire [7:0]  MEM_DBG_RDATA,
  input  wire [7:0]  MEM_CPU_RDATA,
  // Full device erase
  input  wire        ERASE_REQ,
  input  wire        EEPROM_PRESERVE_BIT,
  output reg         ERASE_FLASH,
  output reg         ERASE_EEPROM,
  // Lock state
  output wire        LOCKED
);
  // Key storage: not reset by RESETN, keeps value through resets
  reg  [31:0] memory_lock_key_reg = `MLAG_KEY_RESET;
  reg  [31:0] memory_lock_key_next;

  // Permission results from the two lookups
  wire        dbg_rd_ok;
  wire        dbg_wr_ok;
  wire        cpu_rd_ok;
  wire        cpu_wr_ok;

  // Lock section decode and key write enable
  wire        dbg_key_hit;
  wire        cpu_key_hit;
  wire        dbg_key_we;

  // Key byte read paths
  reg  [7:0]  dbg_key_byte;
  reg  [7:0]  cpu_key_byte;

  // Continuous key compare
  assign LOCKED = (memory_lock_key_reg != `MLAG_KEY_UNLOCK);

  // Debug permission
  mlag_perm u_dbg_perm (
    .is_debug (1'b1),
    .locked   (LOCKED),
    .fuse_cmd (DBG_FUSE_CMD),
    .section  (DBG_SECTION),
    .rd_ok    (dbg_rd_ok),
    .wr_ok    (dbg_wr_ok)
  );

  // CPU permission
  mlag_perm u_cpu_perm (
    .is_debug (1'b0),
    .locked   (LOCKED),
    .fuse_cmd (1'b0),
    .section  (CPU_SECTION),
    .rd_ok    (cpu_rd_ok),
    .wr_ok    (cpu_wr_ok)
  );

  // Key register lives in the lock section; memory bus never sees it
  assign dbg_key_hit = (DBG_SECTION == `MLAG_SEC_LOCK);
  assign cpu_key_hit = (CPU_SECTION == `MLAG_SEC_LOCK);

  // Gate debug requests in the decode cycle
  assign MEM_DBG_RD = DBG_REQ & ~DBG_WE & dbg_rd_ok & ~dbg_key_hit;
  assign MEM_DBG_WR = DBG_REQ &  DBG_WE & dbg_wr_ok & ~dbg_key_hit;

  // Gate CPU requests in the decode cycle
  assign MEM_CPU_RD = CPU_REQ & ~CPU_WE & cpu_rd_ok & ~cpu_key_hit;
  assign MEM_CPU_WR = CPU_REQ &  CPU_WE & cpu_wr_ok & ~cpu_key_hit;

  // Debug write that reaches the key register; locked state refuses it
  assign dbg_key_we = DBG_REQ & DBG_WE & dbg_wr_ok & dbg_key_hit;

  // Next key: byte writes from debug; erase restores unlock value
  always @* begin
    memory_lock_key_next = memory_lock_key_reg;
    if (ERASE_REQ) begin
      memory_lock_key_next = `MLAG_KEY_UNLOCK;
    end else if (dbg_key_we) begin
      case (DBG_ADDR[1:0])
        2'h0:    memory_lock_key_next[7:0]   = DBG_WDATA;
        2'h1:    memory_lock_key_next[15:8]  = DBG_WDATA;
        2'h2:    memory_lock_key_next[23:16] = DBG_WDATA;
        default: memory_lock_key_next[31:24] = DBG_WDATA;
      endcase
    end
  end

  // Key update; CPU write path never reaches it
  always @(posedge MCLK) begin
    memory_lock_key_reg <= memory_lock_key_next;
  end

  // Key byte picked by the debug address
  always @* begin
    case (DBG_ADDR[1:0])
      2'h0:    dbg_key_byte = memory_lock_key_reg[7:0];
      2'h1:    dbg_key_byte = memory_lock_key_reg[15:8];
      2'h2:    dbg_key_byte = memory_lock_key_reg[23:16];
      default: dbg_key_byte = memory_lock_key_reg[31:24];
    endcase
  end

  // Key byte picked by the CPU address
  always @* begin
    case (CPU_ADDR[1:0])
      2'h0:    cpu_key_byte = memory_lock_key_reg[7:0];
      2'h1:    cpu_key_byte = memory_lock_key_reg[15:8];
      2'h2:    cpu_key_byte = memory_lock_key_reg[23:16];
      default: cpu_key_byte = memory_lock_key_reg[31:24];
    endcase
  end

  // Flash erase strobe one cycle after the request
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      ERASE_FLASH <= 1'b0;
    end else begin
      ERASE_FLASH <= ERASE_REQ;
    end
  end

  // EEPROM erase: a locked device ignores the preserve bit
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      ERASE_EEPROM <= 1'b0;
    end else begin
      ERASE_EEPROM <= ERASE_REQ & (LOCKED | ~EEPROM_PRESERVE_BIT);
    end
  end

  // Debug acknowledge for every request, denied or not
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      DBG_ACK <= 1'b0;
    end else begin
      DBG_ACK <= DBG_REQ;
    end
  end

  // Debug read data: denied reads return fixed data
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      DBG_RDATA <= 8'h00;
    end else if (DBG_REQ && !DBG_WE) begin
      if (!dbg_rd_ok)
        DBG_RDATA <= `MLAG_DENY_DATA;
      else if (dbg_key_hit)
        DBG_RDATA <= dbg_key_byte;
      else
        DBG_RDATA <= MEM_DBG_RDATA;
    end
  end

  // CPU acknowledge for every request
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      CPU_ACK <= 1'b0;
    end else begin
      CPU_ACK <= CPU_REQ;
    end
  end

  // CPU read data: key readable, memory data otherwise
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      CPU_RDATA <= 8'h00;
    end else if (CPU_REQ && !CPU_WE) begin
      if (cpu_key_hit)
        CPU_RDATA <= cpu_key_byte;
      else
        CPU_RDATA <= MEM_CPU_RDATA;
    end
  end
endmodule // mlag_guard

/* File: testbench/mlag_mem.sv */
// Purpose: Memory stand-in behind the gate
// Assumes: Data is taken in the strobe cycle
// Notes:   Data is inverted when the strobe is idle
`timescale 1ns/1ps
module mlag_mem (
  // Strobe and address
  input  wire       rd,
  input  wire [7:0] addr,
  // Read data
  output wire [7:0] rdata
);
  // Idle data differs from valid data, so a stray sample cannot match
  assign rdata = rd ? addr ^ 8'hA5 : ~(addr ^ 8'hA5);
endmodule // mlag_mem

/* File: testbench/mlag_chk_asserts.sv */
// Purpose: Port checks for the access gate
// Assumes: Section codes of the map header
// Notes:   Bound to every gate instance
`timescale 1ns/1ps
module mlag_chk (
  // Clock and reset
  input wire       MCLK,
  input wire       RESETN,
  // Debug port request
  input wire       DBG_REQ,
  input wire       DBG_WE,
  input wire       DBG_FUSE_CMD,
  input wire [2:0] DBG_SECTION,
  input wire [7:0] DBG_ADDR,
  input wire [7:0] DBG_WDATA,
  // Debug port answer
  input wire       DBG_ACK,
  input wire [7:0] DBG_RDATA,
  // CPU request
  input wire       CPU_REQ,
  input wire       CPU_WE,
  input wire [2:0] CPU_SECTION,
  // Gated strobes
  input wire       MEM_DBG_RD,
  input wire       MEM_DBG_WR,
  input wire       MEM_CPU_WR,
  // Erase and lock state
  input wire       ERASE_REQ,
  input wire       ERASE_FLASH,
  input wire       ERASE_EEPROM,
  input wire       LOCKED
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  // User row write through the fuse write command
  wire uw = DBG_REQ && DBG_WE && DBG_FUSE_CMD && DBG_SECTION == 3'h4;
  // Wrong key byte for the addressed position
  wire bad = DBG_WDATA != (^DBG_ADDR[1:0] ? 8'hC5 : 8'h5C);
  property p_ack; DBG_REQ |=> DBG_ACK; endproperty
  a_ack: assert property (p_ack) else $error("debug ack missing");
  property p_lkd; LOCKED && DBG_REQ && !uw |-> !MEM_DBG_RD && !MEM_DBG_WR; endproperty
  a_lkd: assert property (p_lkd) else $error("locked access passed");
  property p_deny; LOCKED && DBG_REQ && !DBG_WE |=> DBG_RDATA == 8'h00; endproperty
  a_deny: assert property (p_deny) else $error("denied read data");
  property p_urw; LOCKED && uw |-> MEM_DBG_WR; endproperty
  a_urw: assert property (p_urw) else $error("user row write blocked");
  property p_cpw; CPU_REQ && CPU_WE |-> MEM_CPU_WR == !(CPU_SECTION inside {3, 5, 6}); endproperty
  a_cpw: assert property (p_cpw) else $error("cpu write gate");
  property p_kw; DBG_REQ && DBG_WE && DBG_SECTION == 3'h6 && !ERASE_REQ && bad |=> LOCKED;
  endproperty
  a_kw: assert property (p_kw) else $error("bad key did not lock");
  property p_ers; ERASE_REQ |=> ERASE_FLASH && !LOCKED; endproperty
  a_ers: assert property (p_ers) else $error("erase did not unlock");
  property p_ee; ERASE_REQ && LOCKED |=> ERASE_EEPROM; endproperty
  a_ee: assert property (p_ee) else $error("eeprom kept");
  c_uw: cover property (LOCKED && uw);
  c_er: cover property (ERASE_REQ && LOCKED);
  c_kw: cover property (DBG_REQ && DBG_WE && DBG_SECTION == 3'h6);
endmodule // mlag_chk
bind mlag_guard mlag_chk i_mlag_chk (.*);

/* File: testbench/tb.sv */
// Purpose: Self-checking bench for the access gate
// Assumes: Memory stand-ins answer in the strobe cycle
// Notes:   Row holds lock, section, read and write strobes
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %0t %h %h", $time, a, e); end end
module tb;
  reg        mclk = 0, resetn = 0, req = 0, we = 0, fc = 0, cq = 0, cw = 0, er = 0, es = 0;
  reg  [2:0] sec = 0, csec = 0;
  reg  [7:0] ad = 8'h10, wd = 0, rows [0:15], xr = 0;
  wire [7:0] rdat, mrd, mcd, cd;
  wire       ack, cack, mr, mw, mcr, mcw, ef, ee, lk;
  integer    num_errors = 0, check_count = 0, i;
  always #20 mclk = ~mclk;
  mlag_guard i_mlag_guard (.MCLK(mclk), .RESETN(resetn), .DBG_REQ(req), .DBG_WE(we),
    .DBG_FUSE_CMD(fc), .DBG_SECTION(sec), .DBG_ADDR(ad), .DBG_WDATA(wd), .DBG_RDATA(rdat),
    .DBG_ACK(ack), .CPU_REQ(cq), .CPU_WE(cw), .CPU_SECTION(csec), .CPU_ADDR(ad),
    .CPU_RDATA(cd), .CPU_ACK(cack), .MEM_DBG_RD(mr), .MEM_DBG_WR(mw), .MEM_CPU_RD(mcr),
    .MEM_CPU_WR(mcw), .MEM_DBG_RDATA(mrd), .MEM_CPU_RDATA(mcd), .ERASE_REQ(er),
    .EEPROM_PRESERVE_BIT(es), .ERASE_FLASH(ef), .ERASE_EEPROM(ee), .LOCKED(lk));
  mlag_mem i_mlag_mem (.rd(mr), .addr(ad), .rdata(mrd));
  mlag_mem i_mlag_mem_cpu (.rd(mcr), .addr(ad), .rdata(mcd));
  // Verdict and end of run
  task summarize;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One debug access: strobe in the request cycle, ack and data one cycle later
  task dbg(input w, input f, input [2:0] s, input [7:0] d, input x, input [7:0] xd);
    @(posedge mclk);
    req <= 1; we <= w; fc <= f; sec <= s; wd <= d;
    #1 `CHK(w ? mw : mr, x)
    @(posedge mclk);
    req <= 0;
    #1 `CHK(ack, 1'b1)
    if (!w) `CHK(rdat, xd)
  endtask
  // One processor access; read data checked one cycle after the request
  task cpu(input w, input [2:0] s, input x, input [7:0] xd);
    @(posedge mclk);
    cq <= 1; cw <= w; csec <= s;
    #1 `CHK(w ? mcw : mcr, x)
    @(posedge mclk);
    cq <= 0;
    #1 `CHK(cack, 1'b1)
    if (!w) `CHK(cd, xd)
  endtask
  // Full device erase with the preserve bit given
  task ers(input s, input xe);
    @(posedge mclk);
    er <= 1; es <= s;
    @(posedge mclk);
    er <= 0;
    #1 `CHK({ef, ee, lk}, {1'b1, xe, 1'b0})
  endtask
  initial begin
    rows = '{8'h03, 8'h13, 8'h23, 8'h32, 8'h43, 8'h53, 8'h60, 8'h73,
             8'h80, 8'h90, 8'hA0, 8'hB0, 8'hC1, 8'hD0, 8'hE0, 8'hF0};
    repeat (10) @(posedge mclk);
    resetn <= 1;
    `CHK(lk, 1'b0)
    for (i = 0; i < 16; i++) begin
      if (i == 8) begin
        dbg(1, 0, 3'h6, 8'h00, 0, 0);
        `CHK(lk, 1'b1)
      end
      // Readable memory gives the stand-in's data, the unlocked key its low byte
      xr = rows[i][1] ? 8'hB5 : (i == 6 ? 8'h5C : 8'h00);
      dbg(0, 0, rows[i][6:4], 0, rows[i][1], xr);
      dbg(1, 1, rows[i][6:4], 8'h5C, rows[i][0], 0);
    end
    dbg(1, 0, 3'h4, 0, 0, 0);
    resetn <= 0;
    @(posedge mclk);
    resetn <= 1;
    ad <= 8'h13;
    `CHK(lk, 1'b1)
    cpu(0, 3'h3, 1, 8'hB6);
    cpu(0, 3'h6, 0, 8'h5C);
    cpu(1, 3'h5, 0, 8'h00);
    cpu(1, 3'h0, 1, 8'h00);
    ers(1, 1);
    ers(1, 0);
    summarize;
  end
  // About forty short accesses; a generous multiple of their run time
  initial begin
    #20000;
    num_errors++;
    summarize;
  end
endmodule // tb
